// ===== hdl/sensor_status_regs.svh
// Register addresses, bit positions and timing figures of the status bank
// How it works
// - Writing 1 to an event status bit clears that flag.
// - Writing 0 leaves a set event flag untouched, so new events survive.
// - Event bit 7 flags saturation when the saturation enable is set.
// - Event bit 3 flags a threshold and persistence event when enabled.
// - Event bit 2 flags buffer level; re-asserts while the fill level is nonzero and at or above its threshold.
// - Event bit 0 flags a system event when enabled; cause in mux status.
// - Saturation status bit 6 reads 1 after a measurement completes.
// - Saturation status bit 4 shows the integration counter reached maximum.
// - Saturation status bit 3 shows analog front end saturation.
// - Direction bit 5 shows the event came from exceeding the high threshold.
// - Direction bit 4 shows the event came from falling below low threshold.
// - Mux status bit 2 shows a sensor mux command has finished.
// - Fault bit 7 shows buffer overrun, cleared when the buffer is read.
// - Fault bit 5 shows over temperature, cleared by writing 1.
// - Fault bit 2 shows wait time too short for the integration time.
// - Fault bit 1 reads 1 while sleeping on interrupt; clearing ends sleep.
// - Fault bit 0 stays 1 for about 300 us after power on.
// - Threshold event when result leaves the window for persistence samples.
// - With sleep enabled, stop oscillator on interrupt until all cleared.
`ifndef SENSOR_STATUS_REGS_SVH
`define SENSOR_STATUS_REGS_SVH

`define ADDR_SAT_STATUS 8'h90
`define ADDR_DIR_STATUS 8'h91
`define ADDR_EVENT_STATUS 8'h93
`define ADDR_MUX_STATUS 8'hbb
`define ADDR_FAULT_STATUS 8'hbc

`define REG_RESET 8'h00

`define EV_SAT_BIT 7
`define EV_THRESH_BIT 3
`define EV_BUFFER_BIT 2
`define EV_SYSTEM_BIT 0

`define SAT_DONE_BIT 6
`define SAT_COUNTER_BIT 4
`define SAT_ANALOG_BIT 3

`define DIR_ABOVE_BIT 5
`define DIR_BELOW_BIT 4

`define MUX_DONE_BIT 2

`define FLT_OVERRUN_BIT 7
`define FLT_OVERTEMP_BIT 5
`define FLT_TRIGGER_BIT 2
`define FLT_SLEEP_BIT 1
`define FLT_BUSY_BIT 0

`define INIT_TIME_US 300
`define CLK_FREQ_MHZ 25

`endif

// ===== hdl/sensor_status_pkg.sv
// Types shared by the status bank modules
package sensor_status_pkg;

    typedef logic [7:0] reg_byte_t;

    typedef enum logic [0:0] {
        INIT_RUN = 1'b0,
        INIT_DONE = 1'b1
    } init_state_t;

endpackage

// ===== hdl/threshold_persistence.sv
// Window comparator with consecutive-sample persistence count
`timescale 1ns/1ns
module threshold_persistence #(
    parameter int RESULT_W = 16,
    parameter int PERS_W = 4
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic sample,
    input wire logic [RESULT_W-1:0] result,
    input wire logic [RESULT_W-1:0] low_threshold,
    input wire logic [RESULT_W-1:0] high_threshold,
    input wire logic [PERS_W-1:0] persistence_count,
    output logic event_pulse,
    output logic above_high_threshold,
    output logic below_low_threshold
);
    logic [PERS_W-1:0] run_reg;
    logic [PERS_W-1:0] run_next;
    logic [PERS_W-1:0] need;
    logic is_above;
    logic is_below;
    logic fire;

    assign is_above = result > high_threshold;
    assign is_below = result < low_threshold;
    // A zero count is taken as one, so every outside sample fires
    assign need = (persistence_count == '0) ? PERS_W'(1) : persistence_count;
    // Saturate the run so a long excursion keeps firing
    assign run_next = (run_reg == '1) ? run_reg : run_reg + PERS_W'(1);
    assign fire = sample && (is_above || is_below) && (run_next >= need);

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            run_reg <= '0;
        end
        else if (sample)
        begin
            run_reg <= (is_above || is_below) ? run_next : '0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            event_pulse <= 1'b0;
            above_high_threshold <= 1'b0;
            below_low_threshold <= 1'b0;
        end
        else
        begin
            event_pulse <= fire;
            above_high_threshold <= fire && is_above;
            below_low_threshold <= fire && is_below;
        end
    end
endmodule

// ===== hdl/sensor_event_status_bank.sv
// Status and event flag register bank of the light sensor
`timescale 1ns/1ns
`include "sensor_status_regs.svh"
module sensor_event_status_bank #(
    parameter int INIT_BUSY_CYCLES = `INIT_TIME_US * `CLK_FREQ_MHZ,
    parameter int LEVEL_W = 8,
    parameter int PERS_W = 4
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic saturation_irq_enable,
    input wire logic spectral_irq_enable,
    input wire logic buffer_irq_enable,
    input wire logic system_irq_enable,
    input wire logic sleep_on_irq_enable,
    input wire logic measurement_start,
    input wire logic measurement_done,
    input wire logic counter_saturation,
    input wire logic analog_saturation,
    input wire logic [15:0] channel_zero_result,
    input wire logic [15:0] low_threshold,
    input wire logic [15:0] high_threshold,
    input wire logic [PERS_W-1:0] persistence_count,
    input wire logic [LEVEL_W-1:0] buffer_fill_level,
    input wire logic [LEVEL_W-1:0] buffer_level_threshold,
    input wire logic buffer_read,
    input wire logic buffer_overflow,
    input wire logic over_temperature,
    input wire logic trigger_timing_error,
    input wire logic mux_command_done,
    output logic irq,
    output logic osc_stop,
    output logic init_busy
);
    localparam int CNT_W = $clog2(INIT_BUSY_CYCLES + 1);

    sensor_status_pkg::reg_byte_t event_status_reg;
    sensor_status_pkg::reg_byte_t event_status_next;
    sensor_status_pkg::reg_byte_t sat_status_reg;
    sensor_status_pkg::reg_byte_t dir_status_reg;
    sensor_status_pkg::reg_byte_t mux_status_reg;
    sensor_status_pkg::reg_byte_t fault_status_reg;
    sensor_status_pkg::reg_byte_t rdata_reg;
    sensor_status_pkg::reg_byte_t read_mux;
    sensor_status_pkg::reg_byte_t event_clr;
    sensor_status_pkg::reg_byte_t fault_clr;
    sensor_status_pkg::reg_byte_t event_keep;
    sensor_status_pkg::init_state_t init_state_reg;
    logic [CNT_W-1:0] init_count_reg;
    logic thresh_event;
    logic thresh_above;
    logic thresh_below;
    logic sat_event;
    logic buffer_condition;
    logic any_irq;

    // Flag update where a new event always beats a clear
    function automatic logic flag_next(input logic cur, input logic set,
                                       input logic clr);
        flag_next = set | (cur & ~clr);
    endfunction

    threshold_persistence #(
        .RESULT_W(16),
        .PERS_W(PERS_W)
    ) u_thresh (
        .clk(clk),
        .reset(reset),
        .sample(measurement_done),
        .result(channel_zero_result),
        .low_threshold(low_threshold),
        .high_threshold(high_threshold),
        .persistence_count(persistence_count),
        .event_pulse(thresh_event),
        .above_high_threshold(thresh_above),
        .below_low_threshold(thresh_below)
    );

    assign event_clr = (reg_write && reg_addr == `ADDR_EVENT_STATUS) ?
        reg_wdata : `REG_RESET;
    assign fault_clr = (reg_write && reg_addr == `ADDR_FAULT_STATUS) ?
        reg_wdata : `REG_RESET;
    assign event_keep = event_status_reg & ~reg_wdata;
    assign sat_event = counter_saturation | analog_saturation;
    // Level term: a clear does not drop the flag while data stays at or above the threshold
    assign buffer_condition = buffer_irq_enable &&
        (buffer_fill_level != '0) &&
        (buffer_fill_level >= buffer_level_threshold);

    always_comb
    begin
        event_status_next = `REG_RESET;
        event_status_next[`EV_SAT_BIT] = flag_next(
            event_status_reg[`EV_SAT_BIT],
            saturation_irq_enable & sat_event,
            event_clr[`EV_SAT_BIT]);
        event_status_next[`EV_THRESH_BIT] = flag_next(
            event_status_reg[`EV_THRESH_BIT],
            spectral_irq_enable & thresh_event,
            event_clr[`EV_THRESH_BIT]);
        event_status_next[`EV_BUFFER_BIT] = flag_next(
            event_status_reg[`EV_BUFFER_BIT],
            buffer_condition,
            event_clr[`EV_BUFFER_BIT]);
        event_status_next[`EV_SYSTEM_BIT] = flag_next(
            event_status_reg[`EV_SYSTEM_BIT],
            system_irq_enable & mux_command_done,
            event_clr[`EV_SYSTEM_BIT]);
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            event_status_reg <= `REG_RESET;
        end
        else
        begin
            event_status_reg <= event_status_next;
        end
    end

    // Measurement status lives until the next measurement starts
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sat_status_reg <= `REG_RESET;
        end
        else
        begin
            sat_status_reg[`SAT_DONE_BIT] <= flag_next(
                sat_status_reg[`SAT_DONE_BIT], measurement_done,
                measurement_start);
            sat_status_reg[`SAT_COUNTER_BIT] <= flag_next(
                sat_status_reg[`SAT_COUNTER_BIT], counter_saturation,
                measurement_start);
            sat_status_reg[`SAT_ANALOG_BIT] <= flag_next(
                sat_status_reg[`SAT_ANALOG_BIT], analog_saturation,
                measurement_start);
        end
    end

    // Direction stays with the threshold flag it explains
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            dir_status_reg <= `REG_RESET;
        end
        else
        begin
            dir_status_reg[`DIR_ABOVE_BIT] <= flag_next(
                dir_status_reg[`DIR_ABOVE_BIT], thresh_above,
                event_clr[`EV_THRESH_BIT]);
            dir_status_reg[`DIR_BELOW_BIT] <= flag_next(
                dir_status_reg[`DIR_BELOW_BIT], thresh_below,
                event_clr[`EV_THRESH_BIT]);
        end
    end

    // Cause of the system event, dropped with the system flag
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            mux_status_reg <= `REG_RESET;
        end
        else
        begin
            mux_status_reg[`MUX_DONE_BIT] <= flag_next(
                mux_status_reg[`MUX_DONE_BIT], mux_command_done,
                event_clr[`EV_SYSTEM_BIT]);
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            fault_status_reg <= `REG_RESET;
        end
        else
        begin
            fault_status_reg[`FLT_OVERRUN_BIT] <= flag_next(
                fault_status_reg[`FLT_OVERRUN_BIT], buffer_overflow,
                buffer_read);
            fault_status_reg[`FLT_OVERTEMP_BIT] <= flag_next(
                fault_status_reg[`FLT_OVERTEMP_BIT], over_temperature,
                fault_clr[`FLT_OVERTEMP_BIT]);
            fault_status_reg[`FLT_TRIGGER_BIT] <= trigger_timing_error;
            // Cannot be cleared while an interrupt still holds it
            fault_status_reg[`FLT_SLEEP_BIT] <= flag_next(
                fault_status_reg[`FLT_SLEEP_BIT],
                sleep_on_irq_enable & any_irq,
                fault_clr[`FLT_SLEEP_BIT]);
        end
    end

    // Power-on busy timer
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            init_state_reg <= sensor_status_pkg::INIT_RUN;
            init_count_reg <= '0;
        end
        else
        begin
            case (init_state_reg)
                sensor_status_pkg::INIT_RUN:
                begin
                    if (init_count_reg == CNT_W'(INIT_BUSY_CYCLES - 1))
                    begin
                        init_state_reg <= sensor_status_pkg::INIT_DONE;
                    end
                    else
                    begin
                        init_count_reg <= init_count_reg + CNT_W'(1);
                    end
                end
                sensor_status_pkg::INIT_DONE:
                begin
                    init_state_reg <= sensor_status_pkg::INIT_DONE;
                end
                default:
                begin
                    init_state_reg <= sensor_status_pkg::INIT_RUN;
                end
            endcase
        end
    end

    always_comb
    begin
        case (reg_addr)
            `ADDR_SAT_STATUS: read_mux = sat_status_reg;
            `ADDR_DIR_STATUS: read_mux = dir_status_reg;
            `ADDR_EVENT_STATUS: read_mux = event_status_reg;
            `ADDR_MUX_STATUS: read_mux = mux_status_reg;
            `ADDR_FAULT_STATUS:
            begin
                read_mux = fault_status_reg;
                read_mux[`FLT_BUSY_BIT] = init_busy;
            end
            default: read_mux = `REG_RESET;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rdata_reg <= `REG_RESET;
        end
        else if (reg_read)
        begin
            rdata_reg <= read_mux;
        end
    end

    // Flags only set when enabled, so any set flag counts
    assign any_irq = event_status_reg[`EV_SAT_BIT] |
        event_status_reg[`EV_THRESH_BIT] |
        event_status_reg[`EV_BUFFER_BIT] |
        event_status_reg[`EV_SYSTEM_BIT];
    assign irq = any_irq;
    assign osc_stop = fault_status_reg[`FLT_SLEEP_BIT];
    assign init_busy = (init_state_reg == sensor_status_pkg::INIT_RUN);
    assign reg_rdata = rdata_reg;

    default clocking check_clk @(posedge clk);
    endclocking
    default disable iff (reset);

    AST_W1C_CLEARS: assert property (
        (reg_write && reg_addr == `ADDR_EVENT_STATUS &&
         reg_wdata[`EV_SAT_BIT] && !sat_event)
        |=> !event_status_reg[`EV_SAT_BIT])
        else $error("event flag not cleared by write of one");

    AST_ZERO_KEEPS: assert property (
        (reg_write && reg_addr == `ADDR_EVENT_STATUS)
        |=> ((event_status_reg & $past(event_keep)) == $past(event_keep)))
        else $error("event flag lost on write of zero");

    AST_SAT_SETS: assert property (@(posedge clk) disable iff (reset)
        (saturation_irq_enable && sat_event)
        |=> event_status_reg[`EV_SAT_BIT] ##0 irq)
        else $error("saturation event not flagged");

    AST_THRESH_DIR: assert property (
        (spectral_irq_enable && thresh_event && thresh_above)
        |=> event_status_reg[`EV_THRESH_BIT] && dir_status_reg[`DIR_ABOVE_BIT])
        else $error("high threshold event not recorded");

    AST_BUFFER_REASSERT: assert property (
        buffer_condition |=> event_status_reg[`EV_BUFFER_BIT])
        else $error("buffer level flag not asserted");

    AST_MUX_DONE: assert property (@(posedge clk) disable iff (reset)
        (mux_command_done && system_irq_enable)
        |=> mux_status_reg[`MUX_DONE_BIT] && event_status_reg[`EV_SYSTEM_BIT])
        else $error("mux done not reported");

    AST_OVERRUN_CLEAR: assert property (
        (buffer_read && !buffer_overflow)
        |=> !fault_status_reg[`FLT_OVERRUN_BIT])
        else $error("overrun not cleared by buffer read");

    AST_SLEEP_HOLDS: assert property (
        (sleep_on_irq_enable && any_irq) |=> osc_stop)
        else $error("oscillator running with interrupt pending");

    AST_INIT_LENGTH: assert property (
        $fell(init_busy)
        |-> init_count_reg == CNT_W'(INIT_BUSY_CYCLES - 1))
        else $error("init busy length wrong");

    AST_UNMAPPED_ZERO: assert property (
        (reg_read && reg_addr == `ADDR_EVENT_STATUS + 8'h01)
        |=> reg_rdata == `REG_RESET)
        else $error("unmapped read not zero");

    AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (reset)
        (event_status_reg == `REG_RESET) |-> !irq)
        else $error("interrupt with no flag set");

    COV_SAT: cover property (@(posedge clk) disable iff (reset)
        saturation_irq_enable && sat_event ##1 irq);
    COV_THRESH: cover property (@(posedge clk) disable iff (reset)
        spectral_irq_enable && thresh_event);
    COV_SLEEP: cover property (@(posedge clk) disable iff (reset)
        $rose(osc_stop) ##[1:50] $fell(osc_stop));
    COV_INIT: cover property (@(posedge clk) disable iff (reset)
        $fell(init_busy));
endmodule

// ===== tb/host_model.sv
// Host side model driving the register port of the status bank
`timescale 1ns/1ns
module host_model (
    input wire logic clk,
    input wire logic init_busy,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_write,
    output logic reg_read
);
    logic [7:0] last;

    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        last = 8'h00;
    end

    // Released lines show the inverse, so a stale value never passes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #2;
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(posedge clk);
        #2;
        reg_write = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    // Kept for a later write-back of the serviced flags
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        #2;
        reg_addr = a;
        reg_read = 1'b1;
        @(posedge clk);
        #2;
        reg_read = 1'b0;
        reg_addr = ~a;
        last = reg_rdata;
    endtask

    task automatic service(input logic [7:0] a);
        rd(a);
        wr(a, last);
    endtask

    task automatic wait_ready();
        while (init_busy !== 1'b0)
            @(posedge clk);
    endtask
endmodule

// ===== tb/sensor_event_status_bank_tb.sv
// Self-checking bench for the status and event flag bank
`timescale 1ns/1ns
module sensor_event_status_bank_tb;
    localparam int BUSY = 20;
    localparam logic [7:0] ADDRS [5] = '{8'h90, 8'h91, 8'h93, 8'hbb, 8'hbc};
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_write, reg_read, irq, osc_stop, init_busy;
    logic [4:0] en = 5'h00;
    logic [7:0] ev = 8'h00;
    logic trig = 1'b0;
    logic [15:0] result = 16'h01f4;
    logic [3:0] pers = 4'h2;
    logic [7:0] level = 8'h00;
    logic rd_seen = 1'b0;
    logic [15:0] ent;
    logic [15:0] q[$];
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;
    int seed = 32'h90408687;

    always #20 clk = ~clk;

    sensor_event_status_bank #(.INIT_BUSY_CYCLES(BUSY))
        u_sensor_event_status_bank (
        .clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .saturation_irq_enable(en[0]),
        .spectral_irq_enable(en[1]), .buffer_irq_enable(en[2]),
        .system_irq_enable(en[3]), .sleep_on_irq_enable(en[4]),
        .measurement_start(ev[0]), .measurement_done(ev[1]),
        .counter_saturation(ev[2]), .analog_saturation(ev[3]),
        .channel_zero_result(result), .low_threshold(16'h0064),
        .high_threshold(16'h03e8), .persistence_count(pers),
        .buffer_fill_level(level), .buffer_level_threshold(8'h04),
        .buffer_read(ev[4]), .buffer_overflow(ev[5]),
        .over_temperature(ev[6]), .trigger_timing_error(trig),
        .mux_command_done(ev[7]), .irq(irq), .osc_stop(osc_stop),
        .init_busy(init_busy)
    );

    host_model u_host_model (
        .clk(clk), .init_busy(init_busy), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read)
    );

    task automatic summarize();
        if (fails == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [7:0] e,
                       input logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            $display("BAD %s expected %h seen %h", what, e, g);
            fails++;
        end
    endtask

    task automatic step();
        @(posedge clk);
        #2;
    endtask

    task automatic pulse(input int b);
        step();
        ev[b] = 1'b1;
        step();
        ev[b] = 1'b0;
    endtask

    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        q.push_back({a, e});
        u_host_model.rd(a);
    endtask

    // Read data stands one cycle after the strobe; compared mid-cycle
    always @(posedge clk)
        rd_seen <= reg_read;

    always @(negedge clk)
        if (rd_seen && q.size() > 0)
        begin
            ent = q.pop_front();
            cmp($sformatf("reg_%h", ent[15:8]), ent[7:0], reg_rdata);
        end

    // Whole run is well under a thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            fails++;
            summarize();
        end
    end

    initial
    begin
        int n;
        repeat (16) @(posedge clk);
        #2;
        reset = 1'b0;
        cmp("init_busy", 8'h01, {7'h00, init_busy});
        n = 0;
        while (init_busy !== 1'b0)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        cmp("init_cycles", 8'(BUSY), 8'(n));
        u_host_model.wait_ready();
        for (int i = 0; i < 5; i++)
        begin
            chk(ADDRS[i], 8'h00);
            u_host_model.wr(ADDRS[i], 8'($random(seed)));
            chk(ADDRS[i], 8'h00);
        end
        chk(8'h55, 8'h00);
        chk(8'h94, 8'h00);
        step();
        en = 5'h01;
        pulse(3);
        chk(8'h93, 8'h80);
        chk(8'h90, 8'h08);
        cmp("irq", 8'h01, {7'h00, irq});
        pulse(2);
        chk(8'h90, 8'h18);
        pulse(1);
        chk(8'h90, 8'h58);
        pulse(7);
        chk(8'hbb, 8'h04);
        chk(8'h93, 8'h80);
        // New event lands between the read and the write-back
        chk(8'h93, 8'h80);
        step();
        en = 5'h09;
        pulse(7);
        u_host_model.wr(8'h93, u_host_model.last);
        chk(8'h93, 8'h01);
        u_host_model.wr(8'h93, 8'h01);
        chk(8'h93, 8'h00);
        chk(8'hbb, 8'h00);
        cmp("irq", 8'h00, {7'h00, irq});
        pulse(0);
        chk(8'h90, 8'h00);
        step();
        en = 5'h02;
        for (int i = 0; i < 3; i++)
        begin
            step();
            result = 16'h0064 + 16'($random(seed) & 511);
            pulse(1);
        end
        step();
        result = 16'h07d0;
        pulse(1);
        chk(8'h93, 8'h00);
        pulse(1);
        chk(8'h93, 8'h08);
        chk(8'h91, 8'h20);
        u_host_model.wr(8'h93, 8'h08);
        step();
        result = 16'h0032;
        pulse(1);
        pulse(1);
        chk(8'h91, 8'h10);
        u_host_model.wr(8'h93, 8'h08);
        step();
        en = 5'h04;
        level = 8'h03;
        chk(8'h93, 8'h00);
        level = 8'h05;
        chk(8'h93, 8'h04);
        u_host_model.wr(8'h93, 8'h04);
        chk(8'h93, 8'h04);
        level = 8'h00;
        u_host_model.wr(8'h93, 8'h04);
        chk(8'h93, 8'h00);
        pulse(5);
        chk(8'hbc, 8'h80);
        pulse(4);
        chk(8'hbc, 8'h00);
        pulse(6);
        q.push_back({8'hbc, 8'h20});
        u_host_model.service(8'hbc);
        chk(8'hbc, 8'h00);
        step();
        trig = 1'b1;
        chk(8'hbc, 8'h04);
        trig = 1'b0;
        chk(8'hbc, 8'h00);
        step();
        en = 5'h11;
        pulse(3);
        chk(8'hbc, 8'h02);
        cmp("osc_stop", 8'h01, {7'h00, osc_stop});
        u_host_model.wr(8'hbc, 8'h02);
        chk(8'hbc, 8'h02);
        u_host_model.wr(8'h93, 8'h80);
        u_host_model.wr(8'hbc, 8'h02);
        chk(8'hbc, 8'h00);
        cmp("osc_stop", 8'h00, {7'h00, osc_stop});
        step();
        step();
        summarize();
    end
endmodule
